/* sram_link_pkg.sv */
// Shared constants and types for the burst SRAM port and its controller.
package sram_link_pkg;
    localparam int DATA_W = 36;
    localparam int LANE_W = 9;
    localparam int LANES = 4;
    localparam int ADDR_W = 22;
    localparam int BURST_LEN = 2;
    localparam int FIFO_DEPTH = 16;
    // Read latency counted in link half-cycles (each K or K-bar rise).
    localparam int PLL_LAT_EDGES = 5;
    localparam int LEGACY_LAT_EDGES = 2;
    localparam int PIPE_DEPTH = PLL_LAT_EDGES + BURST_LEN;
    localparam int CORE_PERIOD_NS = 8;
    localparam int K_PERIOD_NS = 160;
    localparam int K_HALF_CYCLES = K_PERIOD_NS / 2 / CORE_PERIOD_NS;
    localparam int K_QUARTER_CYCLES = K_HALF_CYCLES / 2;
    localparam int TERM_CAPTURE_CYCLES = 3;
    localparam logic [LANES-1:0] BWS_NONE = 4'hF;
    localparam logic [DATA_W-1:0] DATA_ZERO = 36'h0_0000_0000;
    localparam logic [DATA_W-1:0] DQ_IDLE_LEVEL = 36'hF_FFFF_FFFF;
    typedef enum logic [4:0] {
        CTRL_IDLE = 5'h01,
        CTRL_CMD = 5'h02,
        CTRL_WD0 = 5'h04,
        CTRL_WD1 = 5'h08,
        CTRL_RD = 5'h10
    } ctrl_state_type;
endpackage

/* sram_link_if.sv */
// Pin-level link between the burst SRAM port and its memory controller.
`timescale 1ns/1ps
interface sram_link_if;
    logic kClk;
    logic kClkN;
    logic loadStrobeN;
    logic readNotWrite;
    logic [sram_link_pkg::ADDR_W-1:0] addr;
    logic [sram_link_pkg::LANES-1:0] byteWriteSelectN;
    logic [sram_link_pkg::DATA_W-1:0] ctrlDqOut;
    logic ctrlDqOeN;
    logic [sram_link_pkg::DATA_W-1:0] devDqOut;
    logic devDqOeN;
    logic [sram_link_pkg::DATA_W-1:0] dqBus;
    logic echoClock;
    logic echoClockN;
    logic outputValidFlag;
    logic pllDisableN;
    logic ctrlTermSelect;
    logic ctrlTermOeN;
    logic terminationRangeSelect;
    // A floating bus idles high; a floating termination strap reads high.
    assign dqBus = !ctrlDqOeN ? ctrlDqOut : (!devDqOeN ? devDqOut : sram_link_pkg::DQ_IDLE_LEVEL);
    assign terminationRangeSelect = ctrlTermOeN ? 1'b1 : ctrlTermSelect;
    modport device (
        input kClk, kClkN, loadStrobeN, readNotWrite, addr, byteWriteSelectN, dqBus,
        input pllDisableN, terminationRangeSelect,
        output devDqOut, devDqOeN, echoClock, echoClockN, outputValidFlag
    );
    modport controller (
        output kClk, kClkN, loadStrobeN, readNotWrite, addr, byteWriteSelectN,
        output ctrlDqOut, ctrlDqOeN, pllDisableN, ctrlTermSelect, ctrlTermOeN,
        input dqBus, echoClock, echoClockN, outputValidFlag
    );
endinterface

/* stream_fifo.sv */
// Synchronous valid/ready FIFO with parameterised width and depth.
`timescale 1ns/1ps
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wrPtr_reg;
    logic [PTR_W-1:0] rdPtr_reg;
    logic [PTR_W:0] count_reg;
    logic push;
    logic pop;

    assign inReady = count_reg != (PTR_W+1)'(DEPTH);
    assign outValid = count_reg != '0;
    assign outData = store[rdPtr_reg];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_ff @(posedge core_clk) begin
        if (push) begin
            store[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wrPtr_reg <= (wrPtr_reg == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
            end
            if (pop) begin
                rdPtr_reg <= (rdPtr_reg == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
            end
            count_reg <= count_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end
endmodule

/* ddr_burst2_sram_port.sv */
// Device end: double-data-rate burst-of-two SRAM with echo clocks.
// Functional notes
// - Write data captured on K and K-bar rises.
// - Read words launched on K and K-bar rises.
// - Data outputs release automatically after read ends.
// - Low load strobe on K rise starts cycle.
// - Each access moves exactly two words.
// - Direction high reads, low writes.
// - Byte selects sampled with their data word.
// - Each select gates one nine-bit lane.
// - Deselected lane leaves stored byte unchanged.
// - One shared address sampled at load.
// - Four mega-words of 36 bits, two arrays.
// - Valid flag marks read data, echo-aligned.
// - Termination range latched at power-up from strap.
// - Floating termination strap selects high range.
// - Accesses begin only on K rise.
// - PLL mode: first word two and a half cycles after load, on K-bar.
// - PLL disabled: one-cycle legacy read latency.
// - Free-running echo clocks follow K.
`timescale 1ns/1ps
module ddr_burst2_sram_port #(
    parameter int ADDR_W = sram_link_pkg::ADDR_W
) (
    input wire logic core_clk,
    input wire logic srst,
    sram_link_if.device link,
    output logic termRangeHigh,
    output logic legacyMode
);
    localparam int DW = sram_link_pkg::DATA_W;
    localparam int LW = sram_link_pkg::LANE_W;
    localparam int NL = sram_link_pkg::LANES;
    localparam int PD = sram_link_pkg::PIPE_DEPTH;
    localparam int ROWS = 2 ** (ADDR_W - 1);

    // Link pins come from another clock's domain: two stages each.
    logic kMeta;
    logic kSync;
    logic kPrev;
    logic knMeta;
    logic knSync;
    logic knPrev;
    logic loadMeta;
    logic loadSyncN;
    logic rnwMeta;
    logic rnwSync;
    logic [ADDR_W-1:0] addrMeta;
    logic [ADDR_W-1:0] addrSync;
    logic [NL-1:0] bwsMeta;
    logic [NL-1:0] bwsSyncN;
    logic [DW-1:0] dqMeta;
    logic [DW-1:0] dqSync;
    logic pllMeta;
    logic pllSyncN;
    logic termMeta;
    logic termSync;

    logic kRise;
    logic knRise;
    logic anyEdge;
    logic readCmd;
    logic writeCmd;

    logic [PD-1:0] rdPipe_reg;
    logic modePrev_reg;
    logic [ADDR_W-1:0] rdAddr_reg [PD];
    logic wrWaitK_reg;
    logic wrWaitKn_reg;
    logic [ADDR_W-1:0] wrAddrK_reg;
    logic [ADDR_W-1:0] wrAddrKn_reg;
    logic [1:0] termCount_reg;

    // Two internal arrays; the burst's two words always fall in different ones.
    logic [DW-1:0] memEven [ROWS];
    logic [DW-1:0] memOdd [ROWS];

    logic wrEn;
    logic wrOdd;
    logic [ADDR_W-2:0] wrRow;
    int latency;
    logic firstWord;
    logic secondWord;
    logic [ADDR_W-1:0] rdAddr;
    logic rdOdd;

    always_ff @(posedge core_clk) begin
        kMeta <= link.kClk;
        kSync <= kMeta;
        kPrev <= kSync;
        knMeta <= link.kClkN;
        knSync <= knMeta;
        knPrev <= knSync;
        loadMeta <= link.loadStrobeN;
        loadSyncN <= loadMeta;
        rnwMeta <= link.readNotWrite;
        rnwSync <= rnwMeta;
        addrMeta <= link.addr[ADDR_W-1:0];
        addrSync <= addrMeta;
        bwsMeta <= link.byteWriteSelectN;
        bwsSyncN <= bwsMeta;
        dqMeta <= link.dqBus;
        dqSync <= dqMeta;
        pllMeta <= link.pllDisableN;
        pllSyncN <= pllMeta;
        termMeta <= link.terminationRangeSelect;
        termSync <= termMeta;
    end

    assign kRise = kSync && !kPrev;
    assign knRise = knSync && !knPrev;
    assign anyEdge = kRise || knRise;
    assign readCmd = kRise && !loadSyncN && rnwSync;
    assign writeCmd = kRise && !loadSyncN && !rnwSync;

    // Read commands walk a pipeline advanced on every K and K-bar rise.
    // A latency change flushes it, so an old command reaches the new tap only on a K or K-bar rise in the change cycle; a read in flight then is lost.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdPipe_reg <= '0;
            modePrev_reg <= 1'b0;
        end else if (legacyMode != modePrev_reg) begin
            rdPipe_reg <= '0;
            modePrev_reg <= legacyMode;
        end else if (anyEdge) begin
            rdPipe_reg <= {rdPipe_reg[PD-2:0], readCmd};
        end
    end

    always_ff @(posedge core_clk) begin
        if (anyEdge) begin
            rdAddr_reg[0] <= addrSync;
            for (int i = 1; i < PD; i++) begin
                rdAddr_reg[i] <= rdAddr_reg[i-1];
            end
        end
    end

    // The first word leaves at the latency edge, the second one edge later.
    always_comb begin
        latency = legacyMode ? sram_link_pkg::LEGACY_LAT_EDGES : sram_link_pkg::PLL_LAT_EDGES;
        firstWord = anyEdge && rdPipe_reg[latency-1];
        secondWord = anyEdge && rdPipe_reg[latency];
        rdAddr = firstWord ? rdAddr_reg[latency-1] : rdAddr_reg[latency];
        rdOdd = firstWord ? rdAddr[0] : !rdAddr[0];
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            link.devDqOut <= sram_link_pkg::DATA_ZERO;
            link.devDqOeN <= 1'b1;
            link.outputValidFlag <= 1'b0;
        end else if (anyEdge) begin
            if (firstWord || secondWord) begin
                link.devDqOut <= rdOdd ? memOdd[rdAddr[ADDR_W-1:1]] : memEven[rdAddr[ADDR_W-1:1]];
                link.devDqOeN <= 1'b0;
                link.outputValidFlag <= 1'b1;
            end else begin
                link.devDqOeN <= 1'b1;
                link.outputValidFlag <= 1'b0;
            end
        end
    end

    // Echo clocks toggle on the same core edge as data, so valid stays aligned.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            link.echoClock <= 1'b0;
            link.echoClockN <= 1'b1;
        end else if (kRise) begin
            link.echoClock <= 1'b1;
            link.echoClockN <= 1'b0;
        end else if (knRise) begin
            link.echoClock <= 1'b0;
            link.echoClockN <= 1'b1;
        end
    end

    // A write's first word arrives on the next K rise, its second on K-bar.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wrWaitK_reg <= 1'b0;
            wrWaitKn_reg <= 1'b0;
            wrAddrK_reg <= '0;
            wrAddrKn_reg <= '0;
        end else begin
            if (kRise) begin
                wrWaitK_reg <= writeCmd;
                if (writeCmd) begin
                    wrAddrK_reg <= addrSync;
                end
                if (wrWaitK_reg) begin
                    wrWaitKn_reg <= 1'b1;
                    wrAddrKn_reg <= wrAddrK_reg;
                end
            end else if (knRise) begin
                wrWaitKn_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        wrEn = 1'b0;
        wrOdd = 1'b0;
        wrRow = '0;
        if (kRise && wrWaitK_reg) begin
            wrEn = 1'b1;
            wrOdd = wrAddrK_reg[0];
            wrRow = wrAddrK_reg[ADDR_W-1:1];
        end else if (knRise && wrWaitKn_reg) begin
            wrEn = 1'b1;
            wrOdd = !wrAddrKn_reg[0];
            wrRow = wrAddrKn_reg[ADDR_W-1:1];
        end
    end

    // Byte selects travel through the same synchroniser as their data word.
    always_ff @(posedge core_clk) begin
        if (wrEn) begin
            for (int l = 0; l < NL; l++) begin
                if (!bwsSyncN[l]) begin
                    if (wrOdd) begin
                        memOdd[wrRow][l*LW +: LW] <= dqSync[l*LW +: LW];
                    end else begin
                        memEven[wrRow][l*LW +: LW] <= dqSync[l*LW +: LW];
                    end
                end
            end
        end
    end

    // The strap is sampled on each of the first three cycles after reset, then held.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            termCount_reg <= '0;
            termRangeHigh <= 1'b1;
            legacyMode <= 1'b0;
        end else begin
            legacyMode <= !pllSyncN;
            if (termCount_reg != 2'(sram_link_pkg::TERM_CAPTURE_CYCLES)) begin
                termCount_reg <= termCount_reg + 1'b1;
                termRangeHigh <= termSync;
            end
        end
    end
endmodule

/* ddr_burst2_sram_ctrl.sv */
// Controller end: makes the K clocks, issues queued bursts, collects reads.
`timescale 1ns/1ps
module ddr_burst2_sram_ctrl #(
    parameter int ADDR_W = sram_link_pkg::ADDR_W,
    parameter int HALF = sram_link_pkg::K_HALF_CYCLES
) (
    input wire logic core_clk,
    input wire logic srst,
    sram_link_if.controller link,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic cmdRead,
    input wire logic [ADDR_W-1:0] cmdAddr,
    input wire logic [sram_link_pkg::DATA_W-1:0] cmdData0,
    input wire logic [sram_link_pkg::DATA_W-1:0] cmdData1,
    input wire logic [sram_link_pkg::LANES-1:0] cmdBws0N,
    input wire logic [sram_link_pkg::LANES-1:0] cmdBws1N,
    input wire logic termHighReq,
    input wire logic pllEnable,
    output logic [sram_link_pkg::DATA_W-1:0] rdData0,
    output logic [sram_link_pkg::DATA_W-1:0] rdData1,
    output logic rdValid
);
    localparam int DW = sram_link_pkg::DATA_W;
    localparam int NL = sram_link_pkg::LANES;
    localparam int FW = 1 + ADDR_W + 2 * DW + 2 * NL;
    localparam int PW = $clog2(2 * HALF);
    localparam int LINK_AW = sram_link_pkg::ADDR_W;

    logic fifoValid;
    logic fifoPop;
    logic [FW-1:0] fifoData;
    logic [FW-1:0] job_reg;
    logic [PW-1:0] phase_reg;
    logic qHigh;
    logic qLow;
    sram_link_pkg::ctrl_state_type state_reg;
    logic echoMeta;
    logic echoSync;
    logic echoPrev;
    logic validMeta;
    logic validSync;
    logic [DW-1:0] dqMeta;
    logic [DW-1:0] dqSync;
    logic gotFirst_reg;

    // The queue fills while a burst is on the link; cmdReady carries the stall.
    stream_fifo #(.WIDTH(FW), .DEPTH(sram_link_pkg::FIFO_DEPTH)) u_stream_fifo (
        .core_clk(core_clk),
        .srst(srst),
        .inValid(cmdValid),
        .inReady(cmdReady),
        .inData({cmdRead, cmdAddr, cmdData0, cmdData1, cmdBws0N, cmdBws1N}),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoData)
    );

    // Signals change at quarter points so they are stable at each K edge.
    assign qHigh = phase_reg == PW'(sram_link_pkg::K_QUARTER_CYCLES);
    assign qLow = phase_reg == PW'(HALF + sram_link_pkg::K_QUARTER_CYCLES);
    assign fifoPop = qLow && state_reg == sram_link_pkg::CTRL_IDLE;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            phase_reg <= '0;
            link.kClk <= 1'b1;
            link.kClkN <= 1'b0;
        end else begin
            phase_reg <= (phase_reg == PW'(2 * HALF - 1)) ? '0 : phase_reg + 1'b1;
            if (phase_reg == PW'(HALF - 1)) begin
                link.kClk <= 1'b0;
                link.kClkN <= 1'b1;
            end else if (phase_reg == PW'(2 * HALF - 1)) begin
                link.kClk <= 1'b1;
                link.kClkN <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        link.pllDisableN <= pllEnable;
        link.ctrlTermSelect <= termHighReq;
        // The high range is asked for by leaving the strap floating, which the far end reads as high.
        link.ctrlTermOeN <= termHighReq;
    end

    always_ff @(posedge core_clk) begin
        echoMeta <= link.echoClock;
        echoSync <= echoMeta;
        echoPrev <= echoSync;
        validMeta <= link.outputValidFlag;
        validSync <= validMeta;
        dqMeta <= link.dqBus;
        dqSync <= dqMeta;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_reg <= sram_link_pkg::CTRL_IDLE;
            job_reg <= '0;
            link.loadStrobeN <= 1'b1;
            link.readNotWrite <= 1'b1;
            link.addr <= '0;
            link.byteWriteSelectN <= sram_link_pkg::BWS_NONE;
            link.ctrlDqOut <= sram_link_pkg::DATA_ZERO;
            link.ctrlDqOeN <= 1'b1;
            rdData0 <= sram_link_pkg::DATA_ZERO;
            rdData1 <= sram_link_pkg::DATA_ZERO;
            rdValid <= 1'b0;
            gotFirst_reg <= 1'b0;
        end else begin
            rdValid <= 1'b0;
            case (state_reg)
                sram_link_pkg::CTRL_IDLE: begin
                    if (fifoPop && fifoValid) begin
                        job_reg <= fifoData;
                        link.loadStrobeN <= 1'b0;
                        link.readNotWrite <= fifoData[FW-1];
                        link.addr <= LINK_AW'(fifoData[FW-2 -: ADDR_W]);
                        state_reg <= sram_link_pkg::CTRL_CMD;
                    end
                end
                sram_link_pkg::CTRL_CMD: begin
                    if (qLow) begin
                        link.loadStrobeN <= 1'b1;
                        if (job_reg[FW-1]) begin
                            gotFirst_reg <= 1'b0;
                            state_reg <= sram_link_pkg::CTRL_RD;
                        end else begin
                            link.ctrlDqOut <= job_reg[2*DW+2*NL-1 -: DW];
                            link.byteWriteSelectN <= job_reg[2*NL-1 -: NL];
                            link.ctrlDqOeN <= 1'b0;
                            state_reg <= sram_link_pkg::CTRL_WD0;
                        end
                    end
                end
                sram_link_pkg::CTRL_WD0: begin
                    if (qHigh) begin
                        link.ctrlDqOut <= job_reg[DW+2*NL-1 -: DW];
                        link.byteWriteSelectN <= job_reg[NL-1:0];
                        state_reg <= sram_link_pkg::CTRL_WD1;
                    end
                end
                sram_link_pkg::CTRL_WD1: begin
                    if (qLow) begin
                        link.ctrlDqOeN <= 1'b1;
                        link.byteWriteSelectN <= sram_link_pkg::BWS_NONE;
                        state_reg <= sram_link_pkg::CTRL_IDLE;
                    end
                end
                sram_link_pkg::CTRL_RD: begin
                    if (validSync && echoSync != echoPrev) begin
                        if (!gotFirst_reg) begin
                            rdData0 <= dqSync;
                            gotFirst_reg <= 1'b1;
                        end else begin
                            rdData1 <= dqSync;
                            rdValid <= 1'b1;
                            state_reg <= sram_link_pkg::CTRL_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= sram_link_pkg::CTRL_IDLE;
                end
            endcase
        end
    end
endmodule

/* sram_link_assertions.sv */
// Concurrent checks on the pins between the burst SRAM port and its controller.
`timescale 1ns/1ps
module sram_link_assertions #(
    parameter int HALF = sram_link_pkg::K_HALF_CYCLES
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic kClk,
    input wire logic loadStrobeN,
    input wire logic readNotWrite,
    input wire logic [sram_link_pkg::LANES-1:0] byteWriteSelectN,
    input wire logic ctrlDqOeN,
    input wire logic devDqOeN,
    input wire logic echoClock,
    input wire logic echoClockN,
    input wire logic outputValidFlag
);
    logic [7:0] validLen_reg;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    // The valid flag must span exactly two link half periods, so its high time is counted.
    always_ff @(posedge core_clk) begin
        if (srst || !outputValidFlag) begin
            validLen_reg <= 8'h00;
        end else begin
            validLen_reg <= validLen_reg + 8'h01;
        end
    end
    property p_no_contention;
        !(!ctrlDqOeN && !devDqOeN);
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("both ends drive the data bus");
    property p_valid_driven;
        outputValidFlag |-> !devDqOeN;
    endproperty
    a_valid_driven: assert property (p_valid_driven) else $error("valid flag without driven data");
    property p_release;
        $fell(outputValidFlag) |-> ##[0:1] devDqOeN;
    endproperty
    a_release: assert property (p_release) else $error("data outputs not released after read");
    property p_valid_echo;
        $changed(outputValidFlag) |-> ($changed(echoClock) || $changed(echoClockN));
    endproperty
    a_valid_echo: assert property (p_valid_echo) else $error("valid flag moved off an echo edge");
    property p_two_words;
        $fell(outputValidFlag) |-> validLen_reg == 2 * HALF;
    endproperty
    a_two_words: assert property (p_two_words) else $error("read burst not two words long");
    property p_echo_runs;
        $rose(echoClock) |-> ##[1:40] $fell(echoClock);
    endproperty
    a_echo_runs: assert property (p_echo_runs) else $error("echo clock stopped");
    property p_load_midlow;
        $changed(loadStrobeN) |-> !kClk;
    endproperty
    a_load_midlow: assert property (p_load_midlow) else $error("load strobe moved near a clock rise");
    property p_bws_with_data;
        (byteWriteSelectN != sram_link_pkg::BWS_NONE) |-> !ctrlDqOeN;
    endproperty
    a_bws_with_data: assert property (p_bws_with_data) else $error("byte selects without write data");
    c_read: cover property ($rose(outputValidFlag));
    c_write: cover property (!loadStrobeN && !readNotWrite);
    c_masked: cover property (byteWriteSelectN != 4'hF && byteWriteSelectN != 4'h0);
endmodule

/* ddr_burst2_sram_port_tb_top.sv */
// Self-checking bench joining the burst SRAM port to its controller.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module ddr_burst2_sram_port_tb_top;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic cmdValid = 1'b0;
    logic cmdReady;
    logic cmdRead = 1'b0;
    logic [7:0] cmdAddr = 8'h00;
    logic [35:0] cmdData0 = 36'h0_0000_0000;
    logic [35:0] cmdData1 = 36'h0_0000_0000;
    logic [3:0] cmdBws0N = 4'hF;
    logic [3:0] cmdBws1N = 4'hF;
    logic termHighReq = 1'b0;
    logic pllEnable = 1'b1;
    logic [35:0] rdData0;
    logic [35:0] rdData1;
    logic rdValid;
    logic termRangeHigh;
    logic legacyMode;
    logic sawFull = 1'b0;
    logic [35:0] expMem [256];
    int n_mismatch = 0;
    int comparisons = 0;
    sram_link_if link();
    ddr_burst2_sram_port #(.ADDR_W(8)) u_ddr_burst2_sram_port (.core_clk(core_clk), .srst(srst), .link(link),
        .termRangeHigh(termRangeHigh), .legacyMode(legacyMode));
    ddr_burst2_sram_ctrl #(.ADDR_W(8)) u_ddr_burst2_sram_ctrl (.core_clk(core_clk), .srst(srst), .link(link),
        .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdRead(cmdRead), .cmdAddr(cmdAddr), .cmdData0(cmdData0),
        .cmdData1(cmdData1), .cmdBws0N(cmdBws0N), .cmdBws1N(cmdBws1N), .termHighReq(termHighReq),
        .pllEnable(pllEnable), .rdData0(rdData0), .rdData1(rdData1), .rdValid(rdValid));
    sram_link_assertions u_sram_link_assertions (.core_clk(core_clk), .srst(srst), .kClk(link.kClk),
        .loadStrobeN(link.loadStrobeN), .readNotWrite(link.readNotWrite), .byteWriteSelectN(link.byteWriteSelectN),
        .ctrlDqOeN(link.ctrlDqOeN), .devDqOeN(link.devDqOeN), .echoClock(link.echoClock),
        .echoClockN(link.echoClockN), .outputValidFlag(link.outputValidFlag));
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] nw, input logic [3:0] bN);
        logic [35:0] r;
        r = old;
        for (int l = 0; l < 4; l++) begin
            if (!bN[l]) begin
                r[l*9 +: 9] = nw[l*9 +: 9];
            end
        end
        return r;
    endfunction
    // Called at a falling edge; leaves the request up so back-to-back calls never toggle it in one step.
    task automatic put(input logic rd, input logic [7:0] a, input logic [35:0] d0, input logic [35:0] d1,
        input logic [3:0] b0, input logic [3:0] b1);
        cmdValid = 1'b1;
        cmdRead = rd;
        cmdAddr = a;
        cmdData0 = d0;
        cmdData1 = d1;
        cmdBws0N = b0;
        cmdBws1N = b1;
        while (cmdReady !== 1'b1) begin
            sawFull = 1'b1;
            @(negedge core_clk);
        end
        @(negedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [35:0] d0, input logic [35:0] d1,
        input logic [3:0] b0, input logic [3:0] b1);
        put(1'b0, a, d0, d1, b0, b1);
        expMem[a] = merge(expMem[a], d0, b0);
        expMem[a ^ 8'h01] = merge(expMem[a ^ 8'h01], d1, b1);
    endtask
    task automatic get(input logic [7:0] a);
        int n;
        n = 0;
        put(1'b1, a, 36'h0_0000_0000, 36'h0_0000_0000, 4'hF, 4'hF);
        cmdValid = 1'b0;
        while (rdValid !== 1'b1 && n < 2000) begin
            @(negedge core_clk);
            n++;
        end
        `CHK("rdValid", 1'b1, rdValid)
        `CHK("rdData0", expMem[a], rdData0)
        `CHK("rdData1", expMem[a ^ 8'h01], rdData1)
    endtask
    task automatic do_reset();
        srst = 1'b1;
        repeat (6) @(negedge core_clk);
        srst = 1'b0;
        repeat (12) @(negedge core_clk);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge core_clk);
        n_mismatch++;
        results();
    end
    initial begin
        do_reset();
        `CHK("termRangeHigh", 1'b0, termRangeHigh)
        $display("test strap_low done");
        wr(8'h10, 36'h1_2345_6789, 36'hA_BCDE_F012, 4'h0, 4'h0);
        cmdValid = 1'b0;
        get(8'h10);
        $display("test full_write done");
        wr(8'h10, 36'hF_0F0F_0F0F, 36'h5_5555_5555, 4'h5, 4'hA);
        cmdValid = 1'b0;
        get(8'h10);
        $display("test byte_mask done");
        for (int i = 0; i < 18; i++) begin
            wr(8'h20 + 8'(2 * i), 36'(i) * 36'h0_0101_0101, ~(36'(i)), 4'h0, 4'h0);
        end
        cmdValid = 1'b0;
        `CHK("queueFull", 1'b1, sawFull)
        get(8'h20);
        get(8'h42);
        $display("test queue_fill done");
        pllEnable = 1'b0;
        repeat (20) @(negedge core_clk);
        `CHK("legacyMode", 1'b1, legacyMode)
        get(8'h10);
        pllEnable = 1'b1;
        repeat (20) @(negedge core_clk);
        get(8'h30);
        $display("test legacy done");
        // The controller now leaves the strap floating.
        termHighReq = 1'b1;
        do_reset();
        `CHK("termRangeHigh", 1'b1, termRangeHigh)
        get(8'h10);
        $display("test strap_high done");
        results();
    end
endmodule
